// *** hdl/pcsp_pkg.sv ***
// constants, types and layouts for the power manager control serial port
// Functional notes
// - Off during supply lockout, on once above.
// - Reset output low until backup rail good, then hold.
// - Debounced warm reset also pulls reset output low.
// - Warm reset restores core default, nothing else.
// - Core setting reverts on any listed reset condition.
// - System converter off forces core code 1xxx0; with the core converter also off the code loads the default core code instead.
// - Latch linear regulator default pins at power-up.
// - Interrupt pin merges all rail good comparators.
// - Status read blocks its active bits from interrupt.
// - Default mask leaves all rail sources unmasked.
// - Mask bit one hides matching status bit.
// - Slave works at standard and fast bus rates.
// - Answer only to bus address 1001000.
// - Unmapped register reads return all ones.
// - Registers hold while supply stays up.
// - Data changes only while bus clock low.
// - Acknowledge every byte once addressed.
// - Release data after master's final no-acknowledge.
// - Read-only version code at address zero.
// - Status at address one, bits seven to one.
// - Sense flags set while input below threshold.
// - Rail fault flag zero while rail disabled.
// - Core fault flag zero during voltage transition.
// - Mask at address two, lockout reloads c0.
package pcsp_pkg;

    // core clock and long times
    localparam int CLK_HZ = 100000000;
    localparam int DEBOUNCE_MS = 30;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int RESET_HOLD_MS = 100;
    localparam int RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 24;

    // serial port
    localparam logic [6:0] SLAVE_ADDR = 7'h48;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] UNMAPPED_READ = 8'hff;

    // register map
    localparam logic [7:0] ADDR_VERSION = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_MASK = 8'h02;
    localparam logic [7:0] VERSION_CODE = 8'h5a; // arbitrary value
    localparam logic [7:0] MASK_RST = 8'hc0;

    // status bit positions
    localparam int ST_PFAIL = 7;
    localparam int ST_LOWBAT = 6;
    localparam int ST_RAIL_LSB = 1;

    // core converter codes; power-up latch delay
    localparam logic [4:0] CORE_CODE_LO = 5'h0c;
    localparam logic [4:0] CORE_CODE_HI = 5'h16;
    localparam logic [1:0] LATCH_DELAY = 2'h3;

    // linear regulator defaults in millivolts
    localparam logic [11:0] MV_1100 = 12'd1100;
    localparam logic [11:0] MV_1300 = 12'd1300;
    localparam logic [11:0] MV_1500 = 12'd1500;
    localparam logic [11:0] MV_2600 = 12'd2600;
    localparam logic [11:0] MV_2800 = 12'd2800;
    localparam logic [11:0] MV_3150 = 12'd3150;
    localparam logic [11:0] MV_3300 = 12'd3300;

    // rail order inside the 5-bit rail vectors: sys, mem, core, linreg_b, linreg_a
    localparam int RAIL_SYS = 4;
    localparam int RAIL_CORE = 2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_REG = 4'h3,
        ST_REG_ACK = 4'h4,
        ST_WDAT = 4'h5,
        ST_WDAT_ACK = 4'h6,
        ST_RDAT = 4'h7,
        ST_RDAT_ACK = 4'h8
    } pcsp_i2c_st_t;

    // pins from outside the clock domain
    typedef struct packed {
        logic scl;
        logic sda;
        logic backup_rail_good;
        logic warm_reset_in;
        logic power_fail_low;
        logic low_battery_low;
        logic [4:0] rail_good;
        logic [4:0] rail_en;
        logic dynamic_voltage_change;
        logic core_default_select;
        logic linreg_a_default_select;
        logic linreg_b_default_select;
    } pcsp_pins_t;

    typedef struct packed {
        pcsp_pins_t s1;
        pcsp_pins_t s2;
        logic scl_q;
        logic sda_q;
        pcsp_i2c_st_t st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic rw;
        logic drv;
        logic ack;
        logic [7:0] mask;
        logic [7:0] blocked;
        logic int_oe;
        logic rst_oe;
        logic [CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0] deb_cnt;
        logic warm_deb;
        logic [4:0] core_code;
        logic [1:0] latch_cnt;
        logic device_on;
        logic [11:0] la_mv;
        logic [11:0] lb_mv;
    } pcsp_state_t;

endpackage

// *** hdl/pcsp_top.sv ***
// control logic of the power manager: serial slave, reset, interrupt, core setting
`timescale 1ns/1ps
module pcsp_top import pcsp_pkg::*; #(
    parameter logic [CNT_W-1:0] DEBOUNCE_CYCLES = CNT_W'(DEBOUNCE_CYC),
    parameter logic [CNT_W-1:0] RESET_HOLD_CYCLES = CNT_W'(RESET_HOLD_CYC)
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic backup_rail_good,
    input wire logic warm_reset_in,
    input wire logic power_fail_sense_low,
    input wire logic low_battery_sense_low,
    input wire logic [4:0] rail_good_comparator,
    input wire logic [4:0] rail_enable,
    input wire logic dynamic_voltage_change,
    input wire logic core_default_select,
    input wire logic linreg_a_default_select,
    input wire logic linreg_b_default_select,
    input wire logic core_code_load,
    input wire logic [4:0] core_code_value,
    output logic system_reset_out_n,
    output logic system_reset_oe,
    output logic int_n,
    output logic int_oe,
    output logic device_on,
    output logic [4:0] core_voltage_code,
    output logic [11:0] linreg_a_mv,
    output logic [11:0] linreg_b_mv
);

    pcsp_state_t q;
    pcsp_state_t n;
    pcsp_pins_t pins;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] status;
    logic status_read;
    logic reset_active;
    logic core_revert;
    logic [7:0] rd_byte;

    // register read decode, shared by first byte and follow-on bytes
    function automatic logic [7:0] reg_read(input logic [7:0] ptr,
                                            input logic [7:0] stat,
                                            input logic [7:0] msk);
        unique case (ptr)
            ADDR_VERSION: reg_read = VERSION_CODE;
            ADDR_STATUS: reg_read = stat;
            ADDR_MASK: reg_read = msk;
            default: reg_read = UNMAPPED_READ;
        endcase
    endfunction

    // default voltage pair from the two latched select pins
    function automatic logic [23:0] linreg_default(input logic b_sel, input logic a_sel);
        unique case ({b_sel, a_sel})
            2'b00: linreg_default = {MV_1100, MV_1300};
            2'b01: linreg_default = {MV_1500, MV_1300};
            2'b10: linreg_default = {MV_2600, MV_2800};
            default: linreg_default = {MV_3150, MV_3300};
        endcase
    endfunction

    // gather the asynchronous pins into one bundle for the synchroniser
    always_comb begin
        pins.scl = scl;
        pins.sda = sda_in;
        pins.backup_rail_good = backup_rail_good;
        pins.warm_reset_in = warm_reset_in;
        pins.power_fail_low = power_fail_sense_low;
        pins.low_battery_low = low_battery_sense_low;
        pins.rail_good = rail_good_comparator;
        pins.rail_en = rail_enable;
        pins.dynamic_voltage_change = dynamic_voltage_change;
        pins.core_default_select = core_default_select;
        pins.linreg_a_default_select = linreg_a_default_select;
        pins.linreg_b_default_select = linreg_b_default_select;
    end

    // bus events seen on the second synchroniser stage only
    assign scl_rise = q.s2.scl & ~q.scl_q;
    assign scl_fall = ~q.s2.scl & q.scl_q;
    assign start_cond = q.s2.scl & q.scl_q & q.sda_q & ~q.s2.sda;
    assign stop_cond = q.s2.scl & q.scl_q & ~q.sda_q & q.s2.sda;

    // live status: a fault only counts while its rail is enabled
    always_comb begin
        status = 8'h00;
        status[ST_PFAIL] = q.s2.power_fail_low;
        status[ST_LOWBAT] = q.s2.low_battery_low;
        status[ST_RAIL_LSB +: 5] = ~q.s2.rail_good & q.s2.rail_en;
        if (q.s2.dynamic_voltage_change) begin
            status[ST_RAIL_LSB + RAIL_CORE] = 1'b0;
        end
    end

    // reset output is active on a weak backup rail, its hold, or warm reset
    assign reset_active = ~q.s2.backup_rail_good | (q.hold_cnt != '0) | q.warm_deb;
    assign core_revert = q.warm_deb | ~q.s2.backup_rail_good | q.rst_oe
        | (~q.s2.rail_en[RAIL_SYS] & ~q.s2.rail_en[RAIL_CORE]);

    assign rd_byte = reg_read(q.ptr, status, q.mask);
    // a status byte counts as read when it is loaded for shifting out
    assign status_read = scl_fall & (q.ptr == ADDR_STATUS)
        & ((q.st == ST_ADDR_ACK & q.rw) | (q.st == ST_RDAT_ACK & q.ack));

    // next-state logic for the whole block
    always_comb begin
        n = q;
        n.s1 = pins;
        n.s2 = q.s1;
        n.scl_q = q.s2.scl;
        n.sda_q = q.s2.sda;

        // serial slave; bits are taken in on the rising clock edge, the data line is only driven on the falling edge
        if (start_cond) begin
            n.st = ST_ADDR;
            n.cnt = 4'h0;
            n.drv = 1'b0;
        end else if (stop_cond) begin
            n.st = ST_IDLE;
            n.drv = 1'b0;
        end else begin
            unique case (q.st)
                ST_IDLE: begin
                    n.drv = 1'b0;
                end
                ST_ADDR, ST_REG, ST_WDAT: begin
                    if (scl_rise) begin
                        n.shreg = {q.shreg[6:0], q.s2.sda};
                        n.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
                        n.cnt = 4'h0;
                        n.drv = 1'b1;
                        if (q.st == ST_ADDR) begin
                            n.rw = q.shreg[0];
                            if (q.shreg[7:1] == SLAVE_ADDR) begin
                                n.st = ST_ADDR_ACK;
                            end else begin
                                n.st = ST_IDLE;
                                n.drv = 1'b0;
                            end
                        end else if (q.st == ST_REG) begin
                            n.ptr = q.shreg;
                            n.st = ST_REG_ACK;
                        end else begin
                            if (q.ptr == ADDR_MASK) begin
                                n.mask = q.shreg;
                            end
                            n.st = ST_WDAT_ACK;
                        end
                    end
                end
                ST_REG_ACK, ST_WDAT_ACK: begin
                    // ninth clock supplied by the master ends the acknowledge
                    if (scl_fall) begin
                        n.drv = 1'b0;
                        n.st = ST_WDAT;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (q.rw) begin
                            n.st = ST_RDAT;
                            n.shreg = rd_byte;
                            n.drv = ~rd_byte[7];
                        end else begin
                            n.st = ST_REG;
                            n.drv = 1'b0;
                        end
                    end
                end
                ST_RDAT: begin
                    if (scl_rise) begin
                        n.cnt = q.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q.cnt == BITS_PER_BYTE) begin
                            n.cnt = 4'h0;
                            n.drv = 1'b0;
                            n.st = ST_RDAT_ACK;
                        end else begin
                            n.shreg = {q.shreg[6:0], 1'b1};
                            n.drv = ~q.shreg[6];
                        end
                    end
                end
                ST_RDAT_ACK: begin
                    if (scl_rise) begin
                        n.ack = ~q.s2.sda;
                    end else if (scl_fall) begin
                        if (q.ack) begin
                            n.st = ST_RDAT;
                            n.shreg = rd_byte;
                            n.drv = ~rd_byte[7];
                        end else begin
                            n.st = ST_IDLE;
                            n.drv = 1'b0;
                        end
                    end
                end
                default: begin
                    n.st = ST_IDLE;
                    n.drv = 1'b0;
                end
            endcase
        end

        // blocking: kept while the bit stays active; a read in the same cycle wins
        n.blocked = (q.blocked & status) | (status_read ? status : 8'h00);
        n.int_oe = |(status & ~q.mask & ~q.blocked);

        // warm reset debounce: the filtered level follows only a stable input
        if (q.s2.warm_reset_in == q.warm_deb) begin
            n.deb_cnt = '0;
        end else if (q.deb_cnt >= DEBOUNCE_CYCLES - CNT_W'(1)) begin
            n.deb_cnt = '0;
            n.warm_deb = q.s2.warm_reset_in;
        end else begin
            n.deb_cnt = q.deb_cnt + CNT_W'(1);
        end

        // hold time restarts on every weak backup rail sample
        if (~q.s2.backup_rail_good) begin
            n.hold_cnt = RESET_HOLD_CYCLES;
        end else if (q.hold_cnt != '0) begin
            n.hold_cnt = q.hold_cnt - CNT_W'(1);
        end
        n.rst_oe = reset_active;

        // core setting: revert wins over the system-off rewrite and over loads
        if (core_revert) begin
            n.core_code = q.s2.core_default_select ? CORE_CODE_HI : CORE_CODE_LO;
        end else if (~q.s2.rail_en[RAIL_SYS]) begin
            n.core_code = {1'b1, q.core_code[3:1], 1'b0};
        end else if (core_code_load) begin
            n.core_code = core_code_value;
        end

        // power-up latch waits for the pins to clear the synchroniser
        if (!q.device_on) begin
            if (q.latch_cnt == LATCH_DELAY) begin
                n.device_on = 1'b1;
                {n.la_mv, n.lb_mv} = linreg_default(q.s2.linreg_b_default_select,
                                                    q.s2.linreg_a_default_select);
            end else begin
                n.latch_cnt = q.latch_cnt + 2'h1;
            end
        end

        // lockout loads every register with its reset value; registers otherwise keep their value
        if (rst) begin
            n = '0;
            n.st = ST_IDLE;
            // bus pins idle high; starting the edge detector low would fake a clock edge
            n.s1.scl = 1'b1;
            n.s1.sda = 1'b1;
            n.s2.scl = 1'b1;
            n.s2.sda = 1'b1;
            n.scl_q = 1'b1;
            n.sda_q = 1'b1;
            n.mask = MASK_RST;
            n.rst_oe = 1'b1;
            n.hold_cnt = RESET_HOLD_CYCLES;
            n.core_code = CORE_CODE_LO;
            {n.la_mv, n.lb_mv} = linreg_default(1'b0, 1'b0);
        end
    end

    // single state register
    always_ff @(posedge core_clk) begin
        q <= n;
    end

    // open-drain pins only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = q.drv;
    assign system_reset_out_n = 1'b0;
    assign system_reset_oe = q.rst_oe;
    assign int_n = 1'b0;
    assign int_oe = q.int_oe;
    assign device_on = q.device_on;
    assign core_voltage_code = q.core_code;
    assign linreg_a_mv = q.la_mv;
    assign linreg_b_mv = q.lb_mv;

endmodule

// *** tb/pcsp_chk.sv ***
// assertion checker for the power manager control port, bound to the top
`timescale 1ns/1ps
module pcsp_chk import pcsp_pkg::*; #(
    parameter logic [CNT_W-1:0] DEBOUNCE_CYCLES = CNT_W'(DEBOUNCE_CYC),
    parameter logic [CNT_W-1:0] RESET_HOLD_CYCLES = CNT_W'(RESET_HOLD_CYC)
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_oe,
    input wire logic backup_rail_good,
    input wire logic warm_reset_in,
    input wire logic power_fail_sense_low,
    input wire logic low_battery_sense_low,
    input wire logic [4:0] rail_good_comparator,
    input wire logic [4:0] rail_enable,
    input wire logic core_default_select,
    input wire logic system_reset_oe,
    input wire logic int_oe,
    input wire logic device_on,
    input wire logic [4:0] core_voltage_code
);
    // windows allow two to three cycles for the pin synchronisers
    localparam int HOLD_LO = int'(RESET_HOLD_CYCLES) - 2;
    localparam int DEB_HI = int'(DEBOUNCE_CYCLES);
    logic fault;
    assign fault = (|(rail_enable & ~rail_good_comparator)) || power_fail_sense_low
        || low_battery_sense_low;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    power_on_a: assert property ($fell(rst) |->
        (system_reset_oe && !int_oe && !device_on) ##[1:5] device_on)
        else $error("device did not come on after lockout");
    weak_backup_a: assert property (!backup_rail_good |-> ##[1:5] system_reset_oe)
        else $error("reset output free while backup rail weak");
    hold_time_a: assert property ($rose(backup_rail_good) |->
        ##[HOLD_LO:HOLD_LO] system_reset_oe ##[1:8] !system_reset_oe)
        else $error("reset hold time wrong");
    warm_reset_a: assert property ($rose(warm_reset_in) ##0 warm_reset_in [*8] |->
        ##[DEB_HI:DEB_HI] system_reset_oe)
        else $error("held warm reset did not reach reset output");
    core_revert_a: assert property (system_reset_oe |=>
        core_voltage_code == (core_default_select ? CORE_CODE_HI : CORE_CODE_LO))
        else $error("core setting not at default during reset");
    sys_off_code_a: assert property (
        (!rail_enable[RAIL_SYS] && rail_enable[RAIL_CORE] && !system_reset_oe) [*5]
        |-> core_voltage_code[4] && !core_voltage_code[0])
        else $error("core code not rewritten with system converter off");
    no_fault_quiet_a: assert property (!fault [*6] |-> !int_oe)
        else $error("interrupt without any fault source");
    data_stable_a: assert property ($changed(sda_oe) |-> !scl)
        else $error("data line moved while bus clock high");

    cover property ($rose(int_oe));
    cover property ($rose(sda_oe));
    cover property ($rose(system_reset_oe) && backup_rail_good);
endmodule

bind pcsp_top pcsp_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES))
    pcsp_chk_i (.core_clk(core_clk), .rst(rst), .scl(scl), .sda_oe(sda_oe),
    .backup_rail_good(backup_rail_good), .warm_reset_in(warm_reset_in),
    .power_fail_sense_low(power_fail_sense_low), .low_battery_sense_low(low_battery_sense_low),
    .rail_good_comparator(rail_good_comparator), .rail_enable(rail_enable),
    .core_default_select(core_default_select), .system_reset_oe(system_reset_oe),
    .int_oe(int_oe), .device_on(device_on), .core_voltage_code(core_voltage_code));

// *** tb/pcsp_host_bfm.sv ***
// bus master model that runs register transfers on the serial port
`timescale 1ns/1ps
module pcsp_host_bfm import pcsp_pkg::*; (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // clock stands still high between frames, data released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // long low phase so the slave's late answer settles before the rise
    task automatic bit_io(input logic b, output logic s);
        #10 sda_pull = !b;
        #40 scl = 1'b1;
        #29 s = sda;
        #1 scl = 1'b0;
    endtask

    // start, or repeated start when the clock is parked low
    task automatic start();
        if (!scl) begin
            #10 sda_pull = 1'b0;
            #40 scl = 1'b1;
        end
        #30 sda_pull = 1'b1;
        #40 scl = 1'b0;
    endtask

    task automatic stop();
        #10 sda_pull = 1'b1;
        #40 scl = 1'b1;
        #30 sda_pull = 1'b0;
        #40;
    endtask

    // eight bits msb first, then the acknowledge clock
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
        output logic ak);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(mack, ak);
    endtask

    // nak is high if any acknowledge missed or the line stayed held
    task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic nak);
        logic [7:0] x;
        logic [3:0] a;
        start();
        xfer({SLAVE_ADDR, 1'b0}, 1'b1, x, a[0]);
        xfer(ra, 1'b1, x, a[1]);
        start();
        xfer({SLAVE_ADDR, 1'b1}, 1'b1, x, a[2]);
        xfer(8'hff, 1'b1, d, a[3]);
        stop();
        nak = (|a[2:0]) | !a[3];
    endtask

    task automatic wr(input logic [7:0] ra, input logic [7:0] d, output logic nak);
        logic [7:0] x;
        logic [2:0] a;
        start();
        xfer({SLAVE_ADDR, 1'b0}, 1'b1, x, a[0]);
        xfer(ra, 1'b1, x, a[1]);
        xfer(d, 1'b1, x, a[2]);
        stop();
        nak = |a;
    endtask

    task automatic probe(input logic [7:0] ab, output logic nak);
        logic [7:0] x;
        start();
        xfer(ab, 1'b1, x, nak);
        stop();
    endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the power manager control port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench import pcsp_pkg::*;;
    localparam int DEB = 20;
    localparam int HOLD = 50;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic backup_ok = 1'b1, warm = 1'b0, pfail = 1'b0, lowbat = 1'b0, dvc = 1'b0, load = 1'b0;
    logic [4:0] good = 5'h1f, en = 5'h1f, load_val = 5'h00;
    logic scl, sda_pull, sda_w, sda_oe, rst_oe, int_oe, dev_on, nak;
    logic sda_lvl, rst_out_n, int_out_n;
    logic core_sel = 1'b0, la_sel = 1'b0, lb_sel = 1'b1;
    logic [4:0] core_code;
    logic [11:0] la_mv, lb_mv;
    int n_mismatch = 0;
    int n_tests = 0;

    always #5 core_clk = ~core_clk;
    // open-drain data wire with its pull-up
    assign sda_w = !(sda_pull || sda_oe);

    pcsp_host_bfm pcsp_host_bfm_i (.scl(scl), .sda_pull(sda_pull), .sda(sda_w));
    pcsp_top #(.DEBOUNCE_CYCLES(24'(DEB)), .RESET_HOLD_CYCLES(24'(HOLD))) pcsp_top_i (
        .core_clk(core_clk), .rst(rst), .scl(scl), .sda_in(sda_w), .sda_out(sda_lvl),
        .sda_oe(sda_oe),
        .backup_rail_good(backup_ok), .warm_reset_in(warm), .power_fail_sense_low(pfail),
        .low_battery_sense_low(lowbat), .rail_good_comparator(good), .rail_enable(en),
        .dynamic_voltage_change(dvc), .core_default_select(core_sel),
        .linreg_a_default_select(la_sel), .linreg_b_default_select(lb_sel),
        .core_code_load(load), .core_code_value(load_val), .system_reset_out_n(rst_out_n),
        .system_reset_oe(rst_oe), .int_n(int_out_n), .int_oe(int_oe), .device_on(dev_on),
        .core_voltage_code(core_code), .linreg_a_mv(la_mv), .linreg_b_mv(lb_mv));

    // inputs always move 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] ra, input logic [7:0] e);
        logic [7:0] d;
        pcsp_host_bfm_i.rd(ra, d, nak);
        `CHK("read ack", 1'b0, nak)
        `CHK("read data", e, d)
    endtask

    task automatic wr_chk(input logic [7:0] ra, input logic [7:0] d);
        pcsp_host_bfm_i.wr(ra, d, nak);
        `CHK("write ack", 1'b0, nak)
    endtask

    task automatic load_code(input logic [4:0] v);
        load_val = v;
        load = 1'b1;
        cyc(1);
        load = 1'b0;
        cyc(2);
        `CHK("load", v, core_code)
    endtask

    task automatic t_power();
        `CHK("on", 1'b1, dev_on)
        `CHK("linreg a", MV_2600, la_mv)
        `CHK("linreg b", MV_2800, lb_mv)
        `CHK("core", CORE_CODE_LO, core_code)
        `CHK("pin levels", 3'h0, {sda_lvl, rst_out_n, int_out_n})
        cyc(HOLD + 10);
        `CHK("rst out", 1'b0, rst_oe)
        `CHK("int idle", 1'b0, int_oe)
    endtask

    task automatic t_backup();
        backup_ok = 1'b0;
        cyc(6);
        `CHK("rst weak", 1'b1, rst_oe)
        backup_ok = 1'b1;
        cyc(HOLD - 6);
        `CHK("rst hold", 1'b1, rst_oe)
        cyc(12);
        `CHK("rst free", 1'b0, rst_oe)
    endtask

    task automatic t_regs();
        rd_chk(ADDR_VERSION, VERSION_CODE);
        rd_chk(ADDR_MASK, MASK_RST);
        rd_chk(8'h03, UNMAPPED_READ);
        wr_chk(ADDR_VERSION, 8'h00);
        rd_chk(ADDR_VERSION, VERSION_CODE);
        pcsp_host_bfm_i.probe({7'h49, 1'b0}, nak);
        `CHK("other addr", 1'b1, nak)
    endtask

    // faults on enabled, disabled and transitioning rails, then block and mask
    task automatic t_int();
        pfail = 1'b1;
        lowbat = 1'b1;
        good = 5'h18;
        en = 5'h1d;
        dvc = 1'b1;
        cyc(8);
        `CHK("int set", 1'b1, int_oe)
        rd_chk(ADDR_STATUS, 8'hc2);
        cyc(4);
        `CHK("int blocked", 1'b0, int_oe)
        good = 5'h10;
        cyc(8);
        `CHK("int new", 1'b1, int_oe)
        wr_chk(ADDR_MASK, 8'hd0);
        rd_chk(ADDR_MASK, 8'hd0);
        `CHK("int masked", 1'b0, int_oe)
        {pfail, lowbat, dvc} = 3'h0;
        good = 5'h1f;
        en = 5'h1f;
    endtask

    task automatic t_warm();
        load_code(5'h0b);
        wr_chk(ADDR_MASK, 8'h3e);
        warm = 1'b1;
        cyc(6);
        warm = 1'b0;
        cyc(DEB);
        `CHK("glitch", 1'b0, rst_oe)
        warm = 1'b1;
        cyc(DEB + 10);
        `CHK("warm rst", 1'b1, rst_oe)
        `CHK("warm core", CORE_CODE_LO, core_code)
        warm = 1'b0;
        cyc(DEB + 10);
        `CHK("warm free", 1'b0, rst_oe)
        rd_chk(ADDR_MASK, 8'h3e);
    endtask

    task automatic t_sys_off();
        load_code(5'h0b);
        en = 5'h0f;
        cyc(6);
        `CHK("sys off", 5'h1a, core_code)
        en = 5'h0b;
        cyc(6);
        `CHK("both off", CORE_CODE_LO, core_code)
        core_sel = 1'b1;
        cyc(6);
        `CHK("both off hi", CORE_CODE_HI, core_code)
        core_sel = 1'b0;
        en = 5'h1f;
    endtask

    // second lockout mid-run: defaults reload and select pins are latched again
    task automatic t_lockout();
        la_sel = 1'b1;
        lb_sel = 1'b0;
        rst = 1'b1;
        cyc(2);
        `CHK("off", 1'b0, dev_on)
        rst = 1'b0;
        cyc(8);
        `CHK("on again", 1'b1, dev_on)
        `CHK("linreg a 01", MV_1500, la_mv)
        `CHK("linreg b 01", MV_1300, lb_mv)
        rd_chk(ADDR_MASK, MASK_RST);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        cyc(12);
        rst = 1'b0;
        cyc(8);
        t_power();
        t_backup();
        t_regs();
        t_int();
        t_warm();
        t_sys_off();
        t_lockout();
        stop_test();
    end

    // whole run needs well under a third of this span
    initial begin
        #500000;
        n_mismatch++;
        stop_test();
    end
endmodule
